// [locm_regs.svh]
`ifndef LOCM_REGS_SVH
`define LOCM_REGS_SVH
// register address and layout
`define LOCM_OSC_CTRL_ADDR    8'hca
`define LOCM_OSC_CTRL_RESET   8'h00
`define LOCM_OSC_CTRL_MASK    8'h1e
`define LOCM_BIT_HSTOP        1
`define LOCM_BIT_CLKSEL       2
`define LOCM_BIT_MODE_LO      3
`define LOCM_BIT_MODE_HI      4
// timing counts
`define LOCM_CFG_CYCLES       12'h7ff
`define LOCM_XTAL_WARM_CYCLES 12'h7ff
`define LOCM_RC_WARM_CYCLES   12'h01f
`define LOCM_SLOW_DIV         2'h3
`define LOCM_CNT_ZERO         12'h000
`endif

// [locm_pkg.sv]
package locm_pkg;
	// cpu mode field codes
	typedef enum logic [1:0] {
		LOCM_MODE_NORMAL = 2'h0,
		LOCM_MODE_SLEEP  = 2'h1,
		LOCM_MODE_GREEN  = 2'h2,
		LOCM_MODE_RSVD   = 2'h3
	} locm_mode_e;
	// high clock option
	typedef enum logic [2:0] {
		LOCM_HOPT_INTERNAL_HIGH_RC_OSC     = 3'h0,
		LOCM_HOPT_INTERNAL_HIGH_WITH_RTC_OPTION = 3'h1,
		LOCM_HOPT_RC       = 3'h2,
		LOCM_HOPT_32K      = 3'h3,
		LOCM_HOPT_12M      = 3'h4,
		LOCM_HOPT_4M       = 3'h5
	} locm_hopt_e;
	// sequencer states, one-hot
	typedef enum logic [3:0] {
		LOCM_ST_CFG  = 4'h1,
		LOCM_ST_WARM = 4'h2,
		LOCM_ST_RUN  = 4'h4,
		LOCM_ST_LOW  = 4'h8
	} locm_state_e;
endpackage : locm_pkg

// [locm_tick_if.sv]
interface locm_tick_if;
	logic lo_tick;
	logic hi_tick;
	logic lo_run;
	logic hi_run;
	modport src (output lo_tick, output hi_tick, input lo_run, input hi_run);
	modport dst (input lo_tick, input hi_tick, output lo_run, output hi_run);
endinterface : locm_tick_if

// [locm_tick_gate.sv]
`include "locm_regs.svh"
// gates raw oscillator ticks by run enables, divides low clock for slow mode
module locm_tick_gate (
	// clock and reset
	input  wire logic i_sys_clk,
	input  wire logic i_nrst,
	input  wire logic i_ce,
	// raw ticks
	input  wire logic i_lo_tick_raw,
	input  wire logic i_hi_tick_raw,
	// gated ticks
	locm_tick_if.src  tk,
	output logic      o_slow_tick
);
	logic [1:0] div_reg;

	// a stopped oscillator gives no ticks
	assign tk.lo_tick = i_lo_tick_raw & tk.lo_run;
	assign tk.hi_tick = i_hi_tick_raw & tk.hi_run;

	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			div_reg     <= 2'h0;
			o_slow_tick <= 1'b0;
		end else if (i_ce) begin
			o_slow_tick <= 1'b0;
			if (tk.lo_tick) begin
				div_reg     <= div_reg + 2'h1;
				o_slow_tick <= (div_reg == `LOCM_SLOW_DIV);
			end
		end
	end
endmodule : locm_tick_gate

// [locm_ctrl.sv]
`include "locm_regs.svh"
// Summary of operation
// - slow mode instruction rate is low rc clock divided by four
// - low rc clock also feeds the watchdog timer
// - low rc stops only in sleep, or green with 32k option and watchdog off
// - that green case leaves only the 32k oscillator running
// - no separate low rc off control exists
// - control register at 0xca, bits 4..1 read/write, others read zero
// - bit 1 stops the high oscillator; low rc keeps running
// - bit 2 selects slow mode on the low rc clock
// - mode field 00 normal, 01 sleep, 10 green, 11 reserved
// - stop bit halts whichever high source is active
// - rtc option stop halts high rc and crystal; internal rc option high rc only; others external only
// - sleep stops external high and low rc oscillators
// - power-up waits 2048 low rc periods for configuration
// - any reset waits 2048 high oscillator periods of warm-up
// - sleep wake waits 2048 periods for crystal, 32 for rc
// - wake clears the matching mode bit
// - slow mode alone does not stop the high oscillator
module locm_ctrl #(
	parameter logic [11:0] CFG_CYCLES  = `LOCM_CFG_CYCLES,
	parameter logic [11:0] XTAL_CYCLES = `LOCM_XTAL_WARM_CYCLES,
	parameter logic [11:0] RC_CYCLES   = `LOCM_RC_WARM_CYCLES
) (
	// clock and reset
	input  wire logic       i_sys_clk,
	input  wire logic       i_nrst,
	input  wire logic       i_ce,
	// register port
	input  wire logic [7:0] i_addr,
	input  wire logic [7:0] i_wdata,
	input  wire logic       i_wr,
	input  wire logic       i_rd,
	output logic      [7:0] o_rdata,
	// options and events
	input  wire logic [2:0] i_high_opt,
	input  wire logic       i_wdt_enable,
	input  wire logic       i_wake,
	// oscillator ticks
	input  wire logic       i_lo_tick,
	input  wire logic       i_hi_tick,
	// oscillator enables
	output logic            o_low_rc_run,
	output logic            o_high_rc_run,
	output logic            o_ext_osc_run,
	output logic            o_rtc_xtal_run,
	// clock consumers
	output logic            o_wdt_tick,
	output logic            o_cpu_slow_tick,
	output logic            o_cpu_use_slow,
	output logic            o_cpu_run,
	output logic            o_busy
);
	logic [1:0]            mode_reg;
	logic                  clksel_reg;
	logic                  hstop_reg;
	logic [11:0]           cnt_reg;
	locm_pkg::locm_state_e st_reg;
	logic                  sleeping;
	logic                  green;
	logic                  rtc_opt;
	logic                  internal_high_rc_osc_opt;
	logic                  rc_type;
	logic                  hi_active;
	logic                  lo_stop;
	logic                  wr_hit;
	logic [7:0]            reg_view;

	locm_tick_if tk ();

	// divider and gating of raw ticks
	locm_tick_gate u_gate (
		.i_sys_clk     (i_sys_clk),
		.i_nrst        (i_nrst),
		.i_ce          (i_ce),
		.i_lo_tick_raw (i_lo_tick),
		.i_hi_tick_raw (i_hi_tick),
		.tk            (tk.src),
		.o_slow_tick   (o_cpu_slow_tick)
	);

	// mode decode, reserved code counts as normal
	// field decode
	assign sleeping = (st_reg == locm_pkg::LOCM_ST_LOW) &&
	                  (mode_reg == locm_pkg::LOCM_MODE_SLEEP);
	assign green    = (st_reg == locm_pkg::LOCM_ST_LOW) &&
	                  (mode_reg == locm_pkg::LOCM_MODE_GREEN);
	assign rtc_opt  = (i_high_opt == locm_pkg::LOCM_HOPT_INTERNAL_HIGH_WITH_RTC_OPTION);
	assign internal_high_rc_osc_opt = (i_high_opt == locm_pkg::LOCM_HOPT_INTERNAL_HIGH_RC_OSC) || rtc_opt;
	assign rc_type  = internal_high_rc_osc_opt || (i_high_opt == locm_pkg::LOCM_HOPT_RC);

	// only two low rc stop cases
	// 32k green keeps only the 32k oscillator
	assign lo_stop = sleeping ||
	                 (green && (i_high_opt == locm_pkg::LOCM_HOPT_32K) && !i_wdt_enable);

	// stop bit halts high side only
	assign hi_active = !hstop_reg && !sleeping;

	// oscillator enables per option
	// rtc option also halts crystal
	assign o_high_rc_run  = internal_high_rc_osc_opt && hi_active;
	assign o_ext_osc_run  = !internal_high_rc_osc_opt && hi_active;
	assign o_rtc_xtal_run = rtc_opt && hi_active;
	assign o_low_rc_run   = !lo_stop;
	assign tk.lo_run      = o_low_rc_run;
	assign tk.hi_run      = hi_active;

	assign o_wdt_tick = tk.lo_tick;

	assign o_cpu_use_slow = clksel_reg;
	assign o_cpu_run      = (st_reg == locm_pkg::LOCM_ST_RUN);
	assign o_busy         = !o_cpu_run;

	assign wr_hit   = i_wr && (i_addr == `LOCM_OSC_CTRL_ADDR);
	assign reg_view = {3'h0, mode_reg, clksel_reg, hstop_reg, 1'b0} & `LOCM_OSC_CTRL_MASK;

	// read data one cycle after the strobe, zero elsewhere
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_rdata <= 8'h00;
		end else if (i_ce) begin
			if (i_rd && (i_addr == `LOCM_OSC_CTRL_ADDR)) begin
				o_rdata <= reg_view;
			end else begin
				o_rdata <= 8'h00;
			end
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			hstop_reg  <= 1'b0;
			clksel_reg <= 1'b0;
		end else if (i_ce && wr_hit) begin
			hstop_reg  <= i_wdata[`LOCM_BIT_HSTOP];
			clksel_reg <= i_wdata[`LOCM_BIT_CLKSEL];
		end
	end

	// mode bits: wake clears them, and the wake wins over a same-cycle write
	// because the core is halted then and cannot write anyway
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			mode_reg <= 2'h0;
		end else if (i_ce) begin
			if (st_reg == locm_pkg::LOCM_ST_LOW && i_wake) begin
				mode_reg <= 2'h0;
			end else if (wr_hit) begin
				mode_reg <= i_wdata[`LOCM_BIT_MODE_HI:`LOCM_BIT_MODE_LO];
			end
		end
	end

	// sequencer: configuration, warm-up, run, low power
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			st_reg       <= locm_pkg::LOCM_ST_CFG;
			cnt_reg      <= CFG_CYCLES;
		end else if (i_ce) begin
			case (st_reg)
				locm_pkg::LOCM_ST_CFG: begin
					if (tk.lo_tick) begin
						if (cnt_reg == `LOCM_CNT_ZERO) begin
							st_reg       <= locm_pkg::LOCM_ST_WARM;
							cnt_reg      <= XTAL_CYCLES;
						end else begin
							cnt_reg <= cnt_reg - 12'h001;
						end
					end
				end
				// reset warm-up of 2048 high periods
				// sleep wake count loaded on wake
				locm_pkg::LOCM_ST_WARM: begin
					if (tk.hi_tick) begin
						if (cnt_reg == `LOCM_CNT_ZERO) begin
							st_reg <= locm_pkg::LOCM_ST_RUN;
						end else begin
							cnt_reg <= cnt_reg - 12'h001;
						end
					end
				end
				locm_pkg::LOCM_ST_RUN: begin
					// entry on a write of sleep or green; reserved stays running
					if (wr_hit && (i_wdata[`LOCM_BIT_MODE_HI:`LOCM_BIT_MODE_LO] ==
					    locm_pkg::LOCM_MODE_SLEEP ||
					    i_wdata[`LOCM_BIT_MODE_HI:`LOCM_BIT_MODE_LO] ==
					    locm_pkg::LOCM_MODE_GREEN)) begin
						st_reg <= locm_pkg::LOCM_ST_LOW;
					end
				end
				locm_pkg::LOCM_ST_LOW: begin
					if (i_wake) begin
						if (mode_reg == locm_pkg::LOCM_MODE_SLEEP) begin
							st_reg  <= locm_pkg::LOCM_ST_WARM;
							cnt_reg <= rc_type ? RC_CYCLES : XTAL_CYCLES;
						end else begin
							// green keeps its clock, no warm-up
							st_reg <= locm_pkg::LOCM_ST_RUN;
						end
					end
				end
				default: begin
					st_reg <= locm_pkg::LOCM_ST_CFG;
				end
			endcase
		end
	end
endmodule : locm_ctrl

// [locm_osc_model.sv]
// oscillator stand-in: low tick every 4th clock, high every 2nd
module locm_osc_model (
	// clock
	input  wire logic i_sys_clk,
	// run enables from the block
	input  wire logic i_lo_run,
	input  wire logic i_hi_run,
	// period ticks
	output logic      o_lo_tick,
	output logic      o_hi_tick
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] ph_reg = 2'h0;
	// free phase, so a stopped osc never ticks
	always_ff @(posedge i_sys_clk) begin
		ph_reg <= ph_reg + 2'h1;
	end
	assign o_lo_tick = i_lo_run && ph_reg == 2'h3;
	assign o_hi_tick = i_hi_run && ph_reg[0];
endmodule : locm_osc_model

// [locm_ctrl_props.sv]
module locm_ctrl_props (
	// clock, reset, bus
	input wire logic       i_sys_clk,
	input wire logic       i_nrst,
	input wire logic       i_ce,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic       i_wr,
	input wire logic       i_rd,
	input wire logic [7:0] o_rdata,
	// options and clocks
	input wire logic [2:0] i_high_opt,
	input wire logic       i_wdt_enable,
	input wire logic       i_lo_tick,
	input wire logic       o_low_rc_run,
	input wire logic       o_high_rc_run,
	input wire logic       o_ext_osc_run,
	input wire logic       o_rtc_xtal_run,
	input wire logic       o_wdt_tick,
	input wire logic       o_cpu_slow_tick,
	input wire logic       o_cpu_use_slow,
	input wire logic       o_cpu_run
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_nrst);
	logic       hit;
	logic [2:0] div_reg;
	// a frozen block takes no write
	assign hit = i_ce && i_wr && i_addr == 8'hca;
	// gated low ticks since the last slow tick
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) div_reg <= 3'h0;
		else if (i_ce && o_cpu_slow_tick) div_reg <= {2'h0, o_wdt_tick};
		else if (i_ce && o_wdt_tick) div_reg <= div_reg + 3'h1;
	end
	sequence all_off_s;
		!o_cpu_run && !o_low_rc_run && !o_high_rc_run && !o_ext_osc_run;
	endsequence
	rd_other_a: assert property (i_ce && i_rd && i_addr != 8'hca |=> o_rdata == 8'h00)
		else $error("stray read data");
	rd_unused_a: assert property (i_rd |=> o_rdata[7:5] == 3'h0 && !o_rdata[0])
		else $error("unused bits set");
	slow_sel_a: assert property (hit |=> o_cpu_use_slow == $past(i_wdata[2]))
		else $error("slow select wrong");
	div_four_a: assert property (o_cpu_slow_tick |-> div_reg == 3'h4)
		else $error("slow tick not every fourth");
	wdt_src_a: assert property (o_wdt_tick == (i_lo_tick && o_low_rc_run))
		else $error("wdt tick without low tick");
	lrc_stop_a: assert property (!o_low_rc_run |-> !o_cpu_run &&
		(!o_high_rc_run && !o_ext_osc_run || i_high_opt == 3'h3 && !i_wdt_enable))
		else $error("low rc stopped wrongly");
	sleep_in_a: assert property (hit && o_cpu_run && i_wdata[4:3] == 2'h1 |=> all_off_s)
		else $error("sleep left an osc on");
	green_32k_a: assert property (hit && o_cpu_run && i_wdata[4:3] == 2'h2 &&
		i_high_opt == 3'h3 && !i_wdt_enable && !i_wdata[1] |=> !o_low_rc_run && o_ext_osc_run)
		else $error("green 32k oscs wrong");
	rsvd_run_a: assert property (hit && o_cpu_run && i_wdata[4:3] == 2'h3 |=> o_cpu_run)
		else $error("reserved mode left run");
	rtc_stop_a: assert property (hit && i_wdata[1] && i_high_opt == 3'h1
		|=> !o_high_rc_run && !o_rtc_xtal_run) else $error("rtc stop failed");
	slow_keep_a: assert property (hit && o_cpu_run && i_wdata[4:1] == 4'h2
		|=> o_high_rc_run || o_ext_osc_run) else $error("slow stopped high osc");
endmodule : locm_ctrl_props
bind locm_ctrl locm_ctrl_props u_props (.i_sys_clk, .i_nrst, .i_ce, .i_addr, .i_wdata, .i_wr,
	.i_rd, .o_rdata, .i_high_opt, .i_wdt_enable, .i_lo_tick, .o_low_rc_run, .o_high_rc_run,
	.o_ext_osc_run, .o_rtc_xtal_run, .o_wdt_tick, .o_cpu_slow_tick, .o_cpu_use_slow, .o_cpu_run);

// [tb_low_clock_and_oscillator_mode_control.sv]
module tb_low_clock_and_oscillator_mode_control;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0, nrst = 1'b0, wstb = 1'b0, rd = 1'b0, wake = 1'b0, wdt = 1'b1;
	logic ce = 1'b1;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
	logic [2:0] opt = 3'h0;
	logic lo, hi, lrc, hrc, ext, run, rtc, busy;
	int fails = 0, n_tests = 0, cyc = 0, n;
	// rows: write data, read back, {run, high rc run}
	logic [23:0] rows [4] = '{24'h020202, 24'h040403, 24'h1e1e02, 24'he10003};
	locm_ctrl #(.CFG_CYCLES(12'h007), .XTAL_CYCLES(12'h00f), .RC_CYCLES(12'h003)) uut (
		.i_sys_clk(clk), .i_nrst(nrst), .i_ce(ce), .i_addr(addr), .i_wdata(wdata),
		.i_wr(wstb), .i_rd(rd), .o_rdata(rdata), .i_high_opt(opt), .i_wdt_enable(wdt),
		.i_wake(wake), .i_lo_tick(lo), .i_hi_tick(hi), .o_low_rc_run(lrc),
		.o_high_rc_run(hrc), .o_ext_osc_run(ext), .o_rtc_xtal_run(rtc), .o_wdt_tick(),
		.o_cpu_slow_tick(), .o_cpu_use_slow(), .o_cpu_run(run), .o_busy(busy));
	locm_osc_model osc (.i_sys_clk(clk), .i_lo_run(lrc), .i_hi_run(hrc || ext),
		.o_lo_tick(lo), .o_hi_tick(hi));
	initial forever #25 clk = ~clk;
	// hang guard, far above the ~250 cycles needed
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			fails++;
			conclude();
		end
	end
	task chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wstb <= 1'b1;
		@(posedge clk);
		wstb <= 1'b0;
	endtask : wr
	task rdc(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk(rdata, exp);
	endtask : rdc
	task wait_run;
		n = 0;
		#1;
		while (run !== 1'b1) begin
			@(posedge clk);
			#1 n++;
		end
	endtask : wait_run
	// enter a low-power mode, check low rc, wake and time the return
	task nap(input logic [7:0] d, input logic lrc_exp);
		wr(8'hca, d);
		@(posedge clk);
		#1 chk({7'h0, lrc}, {7'h0, lrc_exp});
		@(posedge clk);
		wake <= 1'b1;
		@(posedge clk);
		wake <= 1'b0;
		wait_run();
	endtask : nap
	task conclude;
		$display("tests %0d fails %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : conclude
	initial begin
		repeat (10) @(posedge clk);
		nrst <= 1'b1;
		rdc(8'hca, 8'h00);
		wait_run();
		chk(8'(n >= 58), 8'h01);
		chk({7'h0, busy}, 8'h00);
		for (int i = 0; i < 4; i++) begin
			wr(8'hca, rows[i][23:16]);
			rdc(8'hca, rows[i][15:8]);
			chk({6'h0, run, hrc}, rows[i][7:0]);
		end
		// a frozen block ignores a write, as does a foreign address
		ce <= 1'b0;
		wr(8'hca, 8'h1e);
		ce <= 1'b1;
		wr(8'hcb, 8'h1e);
		rdc(8'hca, 8'h00);
		rdc(8'hcb, 8'h00);
		// stop bit per high clock option: {high rc, external, rtc crystal}
		opt <= 3'h1;
		#1 chk({5'h0, hrc, ext, rtc}, 8'h05);
		wr(8'hca, 8'h02);
		#1 chk({5'h0, hrc, ext, rtc}, 8'h00);
		opt <= 3'h5;
		#1 chk({5'h0, hrc, ext, rtc}, 8'h00);
		opt <= 3'h0;
		nap(8'h08, 1'b0);
		chk(8'(n <= 14), 8'h01);
		rdc(8'hca, 8'h00);
		opt <= 3'h2;
		nap(8'h08, 1'b0);
		chk(8'(n <= 14), 8'h01);
		opt <= 3'h4;
		nap(8'h08, 1'b0);
		chk(8'(n >= 28), 8'h01);
		opt <= 3'h3;
		nap(8'h10, 1'b1);
		wdt <= 1'b0;
		nap(8'h10, 1'b0);
		rdc(8'hca, 8'h00);
		// mid-run reset clears the register and repeats the full start-up
		wr(8'hca, 8'h06);
		nrst <= 1'b0;
		#1 chk({7'h0, busy}, 8'h01);
		@(posedge clk);
		nrst <= 1'b1;
		rdc(8'hca, 8'h00);
		wait_run();
		chk(8'(n >= 58), 8'h01);
		chk({7'h0, busy}, 8'h00);
		conclude();
	end
endmodule : tb_low_clock_and_oscillator_mode_control
